// >>> design/ftr_trip_recorder.v
`timescale 1ns/1ps
`include "ftr_defines.vh"
module ftr_trip_recorder #(
   parameter        OVP_HOLD_CYC  = `FTR_OVP_HOLD_CYC,
   parameter        PWR_LOSS_CYC  = `FTR_PWR_LOSS_CYC,
   parameter        CUR_W         = 16,
   parameter        HIST_DEPTH    = 6
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire [CUR_W-1:0] output_current,
   input  wire [CUR_W-1:0] rated_current,
   input  wire [3:0]       drive_state,
   input  wire             thermal_overload,
   input  wire             dc_over_volt,
   input  wire             nvm_fault,
   input  wire             dc_under_volt,
   input  wire             external_trip_input,
   input  wire             unattended_start_guard,
   input  wire             run_cmd,
   input  wire             ground_fault,
   input  wire             powerup_test,
   input  wire             input_over_volt,
   input  wire             input_power_ok,
   input  wire [15:0]      power_fail_allow_time,
   input  wire [1:0]       auto_restart_select,
   input  wire             module_over_temp,
   input  wire [2:0]       phase_ok,
   input  wire             igbt_over_current,
   input  wire             brownout,
   input  wire             restart_failed,
   input  wire             card1_fault,
   input  wire             card2_fault,
   input  wire             stop_reset_key,
   input  wire [1:0]       init_mode,
   input  wire             init_mode_write,
   input  wire [2:0]       hist_sel,
   output wire             output_enable,
   output reg              tripped_q,
   output reg  [7:0]       disp_code_q,
   output reg              disp_dot_q,
   output reg  [3:0]       disp_status_q,
   output reg              restart_pending_q,
   output reg              run_refused_q,
   output wire [11:0]      latest_fault_monitor
);
   localparam S_NORMAL  = 3'h1;
   localparam S_SHUTOFF = 3'h2;
   localparam S_TRIP    = 3'h4;

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg         boot_q;
   reg         guard_q;
   reg  [7:0]  code_d;
   reg         fault_d;
   reg         push_d;
   wire        ovp_armed;
   wire        pwr_lost;
   wire        oc_hit;
   wire [CUR_W+7:0] cur_x100;
   wire [CUR_W+7:0] lim_x150;
   reg  [31:0] unit_cnt_q;
   reg  [15:0] out_units_q;
   reg         long_fail_q;
   wire        unit_end;

   // over-current threshold compare
   assign cur_x100 = {8'h00, output_current} * {{CUR_W{1'b0}}, 8'h64};
   assign lim_x150 = {8'h00, rated_current} * {{CUR_W{1'b0}}, 8'h96};
   assign oc_hit   = (cur_x100 >= lim_x150);

   // codes that carry the status digit
   function has_status;
      input [7:0] c;
      begin
         has_status = (c != `FTR_E_NONE) && (c <= `FTR_E_OVERLOAD);
      end
   endfunction

   // over-current code from motion state
   function [7:0] oc_code;
      input [3:0] st;
      begin
         case (st)
            `FTR_ST_CONST: oc_code = `FTR_E_OC_CONST;
            `FTR_ST_DECEL: oc_code = `FTR_E_OC_DECEL;
            `FTR_ST_ACCEL: oc_code = `FTR_E_OC_ACCEL;
            default:       oc_code = `FTR_E_OC_OTHER;
         endcase
      end
   endfunction

   ftr_timer #(
      .WIDTH (32)
   ) u_ovp_hold (
      .clk    (clk),
      .rstn   (rstn),
      .run    (1'b1),
      .limit  (OVP_HOLD_CYC),
      .done_q (ovp_armed)
   );

   ftr_timer #(
      .WIDTH (32)
   ) u_pwr_loss (
      .clk    (clk),
      .rstn   (rstn),
      .run    (~input_power_ok),
      .limit  (PWR_LOSS_CYC),
      .done_q (pwr_lost)
   );

   // first cycle after reset release: power-up checks
   always @(posedge clk) begin
      if (!rstn) begin
         boot_q  <= 1'b1;
         guard_q <= 1'b0;
      end else begin
         boot_q  <= 1'b0;
         if (boot_q) begin
            guard_q <= unattended_start_guard & run_cmd;
         end else if (state_q == S_TRIP && stop_reset_key) begin
            guard_q <= 1'b0;
         end
      end
   end

   // outage length in allowance units; one unit is one loss-detection window
   assign unit_end = (unit_cnt_q >= PWR_LOSS_CYC - 1);

   always @(posedge clk) begin
      if (!rstn || input_power_ok) begin
         unit_cnt_q  <= 32'h0;
         out_units_q <= 16'h0000;
      end else if (unit_end) begin
         unit_cnt_q <= 32'h0;
         if (out_units_q != 16'hFFFF) begin
            out_units_q <= out_units_q + 16'h0001;
         end
      end else begin
         unit_cnt_q <= unit_cnt_q + 32'h1;
      end
   end

   // outage beyond the allowance is a power failure, kept until power is back with run off
   always @(posedge clk) begin
      if (!rstn) begin
         long_fail_q <= 1'b0;
      end else if (!input_power_ok && out_units_q > power_fail_allow_time) begin
         long_fail_q <= 1'b1;
      end else if (input_power_ok && !run_cmd) begin
         long_fail_q <= 1'b0;
      end
   end

   // fault priority: power stage first
   always @* begin
      fault_d = 1'b1;
      code_d  = `FTR_E_NONE;
      if (igbt_over_current) begin
         code_d = `FTR_E_IGBT;
      end else if (oc_hit) begin
         code_d = oc_code(drive_state);
      end else if (ground_fault && powerup_test) begin
         code_d = `FTR_E_GROUND;
      end else if (module_over_temp) begin
         code_d = `FTR_E_THERMAL;
      end else if (dc_over_volt) begin
         code_d = `FTR_E_OVER_VOLT;
      end else if (thermal_overload) begin
         code_d = `FTR_E_OVERLOAD;
      end else if (nvm_fault) begin
         code_d = `FTR_E_NVM;
      end else if (dc_under_volt) begin
         code_d = `FTR_E_UNDER_VOLT;
      end else if (pwr_lost) begin
         code_d = `FTR_E_PWR_LOSS;
      end else if (phase_ok != 3'h7) begin
         code_d = `FTR_E_PHASE;
      end else if (ovp_armed && input_over_volt) begin
         code_d = `FTR_E_IN_OVP;
      end else if (external_trip_input) begin
         code_d = `FTR_E_EXT_TRIP;
      end else if (guard_q && state_q == S_NORMAL) begin
         code_d = `FTR_E_START_GUARD;
      end else if (card1_fault) begin
         code_d = `FTR_E_CARD1;
      end else if (card2_fault) begin
         code_d = `FTR_E_CARD2;
      end else if (state_q == S_SHUTOFF && restart_failed) begin
         code_d = `FTR_E_UNDER_VOLT;
      end else begin
         fault_d = 1'b0;
      end
   end

   // state machine
   always @* begin
      state_d = state_q;
      push_d  = 1'b0;
      case (state_q)
         S_NORMAL: begin
            if (fault_d) begin
               state_d = S_TRIP;
               push_d  = 1'b1;
            end else if (brownout) begin
               state_d = S_SHUTOFF;
            end
         end
         S_SHUTOFF: begin
            if (fault_d) begin
               state_d = S_TRIP;
               push_d  = 1'b1;
            end else if (!brownout) begin
               state_d = S_NORMAL;
            end
         end
         S_TRIP: begin
            if (stop_reset_key) begin
               state_d = S_NORMAL;
            end
         end
         default: begin
            state_d = S_NORMAL;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state_q           <= S_NORMAL;
         tripped_q         <= 1'b0;
         disp_code_q       <= `FTR_E_NONE;
         disp_dot_q        <= 1'b0;
         disp_status_q     <= `FTR_ST_RESET;
         restart_pending_q <= 1'b0;
         run_refused_q     <= 1'b0;
      end else begin
         state_q       <= state_d;
         tripped_q     <= (state_d == S_TRIP);
         run_refused_q <= guard_q;
         if (push_d) begin
            disp_code_q   <= code_d;
            disp_dot_q    <= has_status(code_d);
            disp_status_q <= drive_state;
         end else if (state_q == S_TRIP && stop_reset_key) begin
            disp_code_q   <= `FTR_E_NONE;
            disp_dot_q    <= 1'b0;
            disp_status_q <= `FTR_ST_RESET;
         end
         // power back after a power failure: restart if run present and enabled
         if (input_power_ok) begin
            restart_pending_q <= long_fail_q && run_cmd && (auto_restart_select != 2'h0);
         end else begin
            restart_pending_q <= 1'b0;
         end
      end
   end

   // output off while tripped, in brownout shutoff, or in any fault
   assign output_enable = rstn && (state_q == S_NORMAL) && !fault_d && !brownout;

   ftr_hist_mem #(
      .WIDTH (12),
      .DEPTH (HIST_DEPTH)
   ) u_hist (
      .clk     (clk),
      .rstn    (rstn),
      .push    (push_d),
      .clear   (init_mode_write && init_mode == `FTR_INIT_CLR_HIST),
      .wdata   ({drive_state, code_d}),
      .rsel    (hist_sel),
      .rdata_q (latest_fault_monitor)
   );
endmodule // ftr_trip_recorder

// >>> include/ftr_defines.vh
`ifndef FTR_DEFINES_VH
`define FTR_DEFINES_VH

// clock rate and timing
`define FTR_CLK_HZ          10000000
`define FTR_OVP_HOLD_S      60
`define FTR_OVP_HOLD_CYC    (`FTR_OVP_HOLD_S * `FTR_CLK_HZ)
`define FTR_PWR_LOSS_MS     15
`define FTR_PWR_LOSS_CYC    ((`FTR_PWR_LOSS_MS * `FTR_CLK_HZ) / 1000 + 1)

// over-current trip level, percent of rated current
`define FTR_OC_PCT          150

// status-at-trip digit
`define FTR_ST_RESET        4'h0
`define FTR_ST_STOP         4'h1
`define FTR_ST_DECEL        4'h2
`define FTR_ST_CONST        4'h3
`define FTR_ST_ACCEL        4'h4
`define FTR_ST_ZERO_REF     4'h5
`define FTR_ST_START        4'h6
`define FTR_ST_DC_BRAKE     4'h7
`define FTR_ST_OL_LIMIT     4'h8

// error codes (decimal number of the code)
`define FTR_E_NONE          8'h00
`define FTR_E_OC_CONST      8'h01
`define FTR_E_OC_DECEL      8'h02
`define FTR_E_OC_ACCEL      8'h03
`define FTR_E_OC_OTHER      8'h04
`define FTR_E_OVERLOAD      8'h05
`define FTR_E_OVER_VOLT     8'h07
`define FTR_E_NVM           8'h08
`define FTR_E_UNDER_VOLT    8'h09
`define FTR_E_EXT_TRIP      8'h0C
`define FTR_E_START_GUARD   8'h0D
`define FTR_E_GROUND        8'h0E
`define FTR_E_IN_OVP        8'h0F
`define FTR_E_PWR_LOSS      8'h10
`define FTR_E_THERMAL       8'h15
`define FTR_E_PHASE         8'h18
`define FTR_E_IGBT          8'h1E
`define FTR_E_CARD1         8'h3C
`define FTR_E_CARD2         8'h46

// initialization mode value that clears the history
`define FTR_INIT_CLR_HIST   2'h0

`endif

// >>> design/ftr_hist_mem.v
`timescale 1ns/1ps
// trip history shift register: slot 0 newest
module ftr_hist_mem #(
   parameter WIDTH = 12,
   parameter DEPTH = 6
) (
   input  wire                     clk,
   input  wire                     rstn,
   input  wire                     push,
   input  wire                     clear,
   input  wire [WIDTH-1:0]         wdata,
   input  wire [2:0]               rsel,
   output reg  [WIDTH-1:0]         rdata_q
);
   wire [WIDTH-1:0] slot_w [0:DEPTH-1];
   genvar i;

   // each slot owns its register; slot 0 takes the new entry, the rest the one before
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_slot
         reg  [WIDTH-1:0] q;
         wire [WIDTH-1:0] nxt;
         if (i == 0) begin : g_head
            assign nxt = wdata;
         end else begin : g_tail
            assign nxt = slot_w[i-1];
         end
         always @(posedge clk) begin
            if (!rstn || clear) begin
               q <= {WIDTH{1'b0}};
            end else if (push) begin
               q <= nxt;
            end
         end
         assign slot_w[i] = q;
      end
   endgenerate

   always @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= {WIDTH{1'b0}};
      end else if (rsel < DEPTH) begin
         rdata_q <= slot_w[rsel];
      end else begin
         rdata_q <= {WIDTH{1'b0}};
      end
   end
endmodule // ftr_hist_mem

// >>> design/ftr_timer.v
`timescale 1ns/1ps
// counts while run is high; done once count reaches limit
module ftr_timer #(
   parameter WIDTH = 32
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire             run,
   input  wire [WIDTH-1:0] limit,
   output reg              done_q
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge clk) begin
      if (!rstn || !run) begin
         cnt_q  <= {WIDTH{1'b0}};
         done_q <= 1'b0;
      end else if (cnt_q >= limit) begin
         done_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // ftr_timer

// >>> tb/ftr_trip_checker.sv
`timescale 1ns/1ps
module ftr_trip_checker #(
   parameter CUR_W = 16
) (
   input wire             clk,
   input wire             rstn,
   input wire [CUR_W-1:0] output_current,
   input wire [CUR_W-1:0] rated_current,
   input wire [3:0]       drive_state,
   input wire             external_trip_input,
   input wire             igbt_over_current,
   input wire             stop_reset_key,
   input wire [1:0]       init_mode,
   input wire             init_mode_write,
   input wire [2:0]       hist_sel,
   input wire             output_enable,
   input wire             tripped_q,
   input wire [7:0]       disp_code_q,
   input wire             disp_dot_q,
   input wire [11:0]      latest_fault_monitor
);
   wire over_cur;
   assign over_cur = 32'(output_current) * 100 >= 32'(rated_current) * 150;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_oe_off; tripped_q |-> !output_enable; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output on in trip");
   property p_clear; tripped_q && stop_reset_key |=> !tripped_q; endproperty
   a_clear: assert property (p_clear) else $error("key did not clear");
   property p_show; $rose(tripped_q) |-> disp_code_q != 8'h00; endproperty
   a_show: assert property (p_show) else $error("no code on trip");
   property p_ext; external_trip_input |-> !output_enable; endproperty
   a_ext: assert property (p_ext) else $error("output on with ext trip");
   property p_oc;
      !tripped_q && over_cur && !igbt_over_current && drive_state == 4'h3
      |=> tripped_q && disp_code_q == 8'h01;
   endproperty
   a_oc: assert property (p_oc) else $error("bad const speed oc");
   property p_igbt; igbt_over_current && !tripped_q |=> tripped_q && disp_code_q == 8'h1E;
   endproperty
   a_igbt: assert property (p_igbt) else $error("bad transistor trip");
   property p_erase;
      (init_mode_write && init_mode == 2'h0 && hist_sel == 3'h0) ##1 (hist_sel == 3'h0)
      |=> latest_fault_monitor == 12'h000;
   endproperty
   a_erase: assert property (p_erase) else $error("history kept");
   property p_depth; hist_sel > 3'h5 |=> latest_fault_monitor == 12'h000; endproperty
   a_depth: assert property (p_depth) else $error("slot beyond depth");
   property p_dot; tripped_q |-> disp_dot_q == (disp_code_q >= 8'h01 && disp_code_q <= 8'h05);
   endproperty
   a_dot: assert property (p_dot) else $error("bad status point");
endmodule // ftr_trip_checker

bind ftr_trip_recorder ftr_trip_checker #(.CUR_W(CUR_W)) ftr_trip_checker_i (
   .clk(clk), .rstn(rstn), .output_current(output_current), .rated_current(rated_current),
   .drive_state(drive_state), .external_trip_input(external_trip_input),
   .igbt_over_current(igbt_over_current), .stop_reset_key(stop_reset_key),
   .init_mode(init_mode), .init_mode_write(init_mode_write), .hist_sel(hist_sel),
   .output_enable(output_enable), .tripped_q(tripped_q), .disp_code_q(disp_code_q),
   .disp_dot_q(disp_dot_q), .latest_fault_monitor(latest_fault_monitor));

// >>> tb/ftr_panel.sv
`timescale 1ns/1ps
// operator keypad stand-in
module ftr_panel (
   input  wire       clk,
   output reg        stop_reset_key,
   output reg  [1:0] init_mode,
   output reg        init_mode_write,
   output reg  [2:0] hist_sel
);
   initial begin
      stop_reset_key  = 1'b0;
      init_mode       = 2'h1;
      init_mode_write = 1'b0;
      hist_sel        = 3'h0;
   end
   task press_clear; begin
      stop_reset_key = 1'b1;
      @(posedge clk);
      #1 stop_reset_key = 1'b0;
   end endtask
   task erase(input [1:0] m); begin
      init_mode       = m;
      init_mode_write = 1'b1;
      @(posedge clk);
      #1 init_mode_write = 1'b0;
   end endtask
   task show(input [2:0] s); begin
      hist_sel = s;
   end endtask
endmodule // ftr_panel

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam [103:0] CODES = {8'h18, 8'h18, 8'h18, 8'h46, 8'h3C, 8'h1E, 8'h15,
                               8'h0E, 8'h0C, 8'h09, 8'h08, 8'h07, 8'h05};
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [12:0] f = 13'h0;
   reg  [15:0] cur = 16'h0;
   reg  [3:0]  ds = 4'h3;
   reg         usg = 1'b0, run = 1'b0, put = 1'b0, iov = 1'b0;
   reg         pok = 1'b1, bro = 1'b0, rfl = 1'b0;
   reg  [15:0] rated = 16'h0064, pfa = 16'h0002;
   reg  [1:0]  ars = 2'h1;
   wire        oe, trp, dot, rr, rp, key, imw;
   wire [7:0]  code;
   wire [3:0]  st;
   wire [1:0]  im;
   wire [2:0]  hs;
   wire [11:0] mon;
   integer     failures = 0, checks_done = 0, i, n;
   always #50 clk = ~clk;
   ftr_trip_recorder #(.OVP_HOLD_CYC(50), .PWR_LOSS_CYC(10)) ftr_trip_recorder_i (
      .clk(clk), .rstn(rstn), .output_current(cur), .rated_current(rated),
      .drive_state(ds), .thermal_overload(f[0]), .dc_over_volt(f[1]), .nvm_fault(f[2]),
      .dc_under_volt(f[3]), .external_trip_input(f[4]), .unattended_start_guard(usg),
      .run_cmd(run), .ground_fault(f[5]), .powerup_test(put), .input_over_volt(iov),
      .input_power_ok(pok), .power_fail_allow_time(pfa), .auto_restart_select(ars),
      .module_over_temp(f[6]), .phase_ok(~f[12:10]), .igbt_over_current(f[7]),
      .brownout(bro), .restart_failed(rfl), .card1_fault(f[8]), .card2_fault(f[9]),
      .stop_reset_key(key), .init_mode(im), .init_mode_write(imw), .hist_sel(hs),
      .output_enable(oe), .tripped_q(trp), .disp_code_q(code), .disp_dot_q(dot),
      .disp_status_q(st), .restart_pending_q(rp), .run_refused_q(rr),
      .latest_fault_monitor(mon));
   ftr_panel ftr_panel_i (.clk(clk), .stop_reset_key(key), .init_mode(im),
      .init_mode_write(imw), .hist_sel(hs));
   task tick; begin
      @(posedge clk);
      #1;
   end endtask
   task chk(input string nm, input [11:0] e, input [11:0] g); begin
      checks_done = checks_done + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
   end endtask
   task summarize; begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   end endtask
   task wait_trip(input integer lim); begin
      n = 0;
      while (trp !== 1'b1 && n < lim) begin
         tick;
         n = n + 1;
      end
      if (trp !== 1'b1) begin
         chk("trip_wait", 1, trp);
         summarize;
      end
   end endtask
   // cause applied just after an edge; checks trip, display, history, clear
   task expect_trip(input [7:0] c); begin
      if (trp !== 1'b1) begin
         #1 chk("oe_fast", 0, oe);
         tick;
      end
      chk("tripped", 1, trp);
      chk("code", c, code);
      chk("dot", c <= 8'h05, dot);
      if (c <= 8'h05) chk("status", ds, st);
      f = 13'h0;
      cur = 16'h0;
      iov = 1'b0;
      pok = 1'b1;
      bro = 1'b0;
      rfl = 1'b0;
      tick;
      chk("hist0", c, mon[7:0]);
      chk("oe_held", 0, oe);
      ftr_panel_i.press_clear;
      chk("cleared", 0, trp);
   end endtask
   initial begin
      repeat (16) tick;
      rstn = 1'b1;
      iov = 1'b1;
      repeat (20) tick;
      chk("ovp_early", 0, trp);
      wait_trip(60);
      expect_trip(8'h0F);
      for (i = 0; i < 9; i = i + 1) begin
         ds = i[3:0];
         cur = 16'h0095;
         tick;
         chk("oc_149", 0, trp);
         cur = 16'h0096;
         expect_trip(i == 3 ? 8'h01 : i == 2 ? 8'h02 : i == 4 ? 8'h03 : 8'h04);
      end
      ds = 4'h3;
      f = 13'h20;
      repeat (2) tick;
      chk("gnd_idle", 0, trp);
      put = 1'b1;
      expect_trip(8'h0E);
      for (i = 0; i < 13; i = i + 1) begin
         f = 13'h1 << i;
         expect_trip(CODES[8*i +: 8]);
      end
      for (i = 0; i < 8; i = i + 1) begin
         ftr_panel_i.show(i[2:0]);
         tick;
         if (i < 6) chk("hist", CODES[8*(12-i) +: 8], mon[7:0]);
         else chk("hist_none", 0, mon);
      end
      ftr_panel_i.show(3'h0);
      ftr_panel_i.erase(2'h1);
      tick;
      chk("kept", 8'h18, mon[7:0]);
      ftr_panel_i.erase(2'h0);
      tick;
      chk("erased", 0, mon);
      run = 1'b1;
      pok = 1'b0;
      repeat (5) tick;
      pok = 1'b1;
      tick;
      chk("short_loss", 0, trp);
      chk("short_pend", 0, rp);
      pok = 1'b0;
      wait_trip(30);
      repeat (30) tick;
      chk("pend_off", 0, rp);
      expect_trip(8'h10);
      chk("restart_pend", 1, rp);
      run = 1'b0;
      tick;
      chk("pend_drop", 0, rp);
      bro = 1'b1;
      #1 chk("bo_off", 0, oe);
      tick;
      chk("bo_nolog", 0, trp);
      rfl = 1'b1;
      expect_trip(8'h09);
      rstn = 1'b0;
      run = 1'b1;
      usg = 1'b1;
      repeat (16) tick;
      rstn = 1'b1;
      wait_trip(5);
      chk("refused", 1, rr);
      expect_trip(8'h0D);
      tick;
      chk("no_recur", 0, trp);
      summarize;
   end
endmodule // testbench
